/* hw/hsc_pkg.sv */
// Package of constants and types for the halt standby controller
package hsc_pkg;

  // ==========================================================
  // Register map (Avalon-MM word addresses, byte address = 4 * index)
  localparam logic [3:0] ADDR_CTRL     = 4'h0;
  localparam logic [3:0] ADDR_STATUS   = 4'h1;
  localparam logic [3:0] ADDR_IRQ_REQ  = 4'h2;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h3;
  localparam logic [3:0] ADDR_CLK_SEL  = 4'h4;
  localparam logic [3:0] ADDR_ID       = 4'h5;

  // ==========================================================
  // Control register fields
  localparam int CTRL_HALT_BIT  = 0;
  localparam int CTRL_IE_BIT    = 1;
  localparam int CTRL_RING_STOP = 2;
  localparam int CTRL_XTAL_STOP = 3;

  // ==========================================================
  // Clock select register fields
  localparam int SEL_IT1_SRC_LO  = 0;
  localparam int SEL_IT1_SRC_HI  = 1;
  localparam int SEL_IT1_TIMER50 = 2;
  localparam int SEL_WATCH_SUB   = 3;
  localparam int SEL_UART_T50    = 4;
  localparam int SEL_CSU_EXT     = 5;
  localparam int SEL_T50_RUN     = 6;

  // Second interval timer count source codes
  localparam logic [1:0] IT2_SRC_CRYSTAL = 2'h0;
  localparam logic [1:0] IT2_SRC_PCLK128 = 2'h1;
  localparam logic [1:0] IT2_SRC_OTHER   = 2'h2;

  // ==========================================================
  // Reset values
  localparam logic [31:0] CTRL_RESET    = 32'h00000000;
  localparam logic [31:0] SEL_RESET     = 32'h00000000;
  localparam logic [31:0] MASK_RESET    = 32'h000000FF;
  // Arbitrary identification value
  localparam logic [31:0] ID_VALUE      = 32'h0000A5C3;

  // ==========================================================
  // Wake-up wait counts in CPU clocks
  localparam logic [3:0] WAIT_VECTOR_CLKS = 4'h8;
  localparam logic [3:0] WAIT_RESUME_CLKS = 4'h2;
  localparam int         IRQ_LINES        = 8;

  typedef enum {
    HSC_RUN,
    HSC_HALTED,
    HSC_WAIT,
    HSC_RESET_SEQ
  } hsc_state_type;

endpackage : hsc_pkg

/* hw/hsc_sync.sv */
// Two-flop synchroniser bank for pin inputs
`timescale 1ns/1ps
module hsc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             CLK,
  input  wire logic             RESET,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      stage1 <= '0;
      q      <= '0;
    end else begin
      stage1 <= d;
      q      <= stage1;
    end
  end
endmodule : hsc_sync

/* hw/hsc_top.sv */
// Halt standby controller: CPU clock gating, peripheral run enables, wake-up
`timescale 1ns/1ps

module hsc_top #(
  parameter bit RING_STOPPABLE = 1'h0
) (
  input  wire logic        CLK,
  input  wire logic        RESET,
  input  wire logic [3:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  input  wire logic        HALT_REQ,
  input  wire logic [7:0]  IRQ_IN,
  input  wire logic        MAIN_CRYSTAL_RUN,
  input  wire logic        INTERNAL_RING_OSCILLATOR_RUN,
  output logic             CPU_CLK_EN,
  output logic             PORT_LATCH_HOLD,
  output logic             CPU_RESUME,
  output logic             CPU_VECTOR,
  output logic             CPU_RESET_VECTOR,
  output logic             IT1_RUN,
  output logic             IT2_RUN,
  output logic             WATCH_RUN,
  output logic             WDT_RUN,
  output logic             ASYNC_SERIAL_A_RUN,
  output logic             ASYNC_SERIAL_B_RUN,
  output logic             CSU_RUN
);
  import hsc_pkg::*;

  // ==========================================================
  // Registers and state
  hsc_state_type      state;
  logic [31:0]        ctrl;
  logic [31:0]        clk_sel;
  logic [7:0]         irq_mask;
  logic [7:0]         irq_req;
  logic [7:0]         irq_sync;
  logic [1:0]         osc_sync;
  logic               rd_pending;
  logic               wake_vector;
  logic               timer_load;
  logic [3:0]         timer_count;
  logic               timer_busy;
  logic               timer_done;
  logic               xtal_on;
  logic               ring_on;
  logic               halted;
  logic               wake;
  logic               wr_hit;
  logic [1:0]         it2_src;
  logic [31:0]        next_readdata;

  // ==========================================================
  // Pin synchronisers
  hsc_sync #(.WIDTH(IRQ_LINES)) u_irq_sync (
    .CLK   (CLK),
    .RESET (RESET),
    .d     (IRQ_IN),
    .q     (irq_sync)
  );

  hsc_sync #(.WIDTH(2)) u_osc_sync (
    .CLK   (CLK),
    .RESET (RESET),
    .d     ({INTERNAL_RING_OSCILLATOR_RUN, MAIN_CRYSTAL_RUN}),
    .q     (osc_sync)
  );

  // Software may also declare an oscillator stopped
  assign xtal_on = osc_sync[0] & ~ctrl[CTRL_XTAL_STOP];
  assign ring_on = osc_sync[1] & ~(RING_STOPPABLE & ctrl[CTRL_RING_STOP]);
  assign halted  = (state == HSC_HALTED);
  // Masked lines are ignored so they cannot wake the core
  assign wake    = |(irq_req & ~irq_mask);
  assign it2_src = clk_sel[SEL_IT1_SRC_HI:SEL_IT1_SRC_LO];
  assign wr_hit  = AVS_WRITE & ~AVS_WAITREQUEST;

  // ==========================================================
  // Avalon slave: one wait cycle on every access
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      rd_pending <= 1'h0;
    end else begin
      rd_pending <= (AVS_READ | AVS_WRITE) & ~rd_pending;
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      AVS_WAITREQUEST <= 1'h1;
    end else begin
      AVS_WAITREQUEST <= ~((AVS_READ | AVS_WRITE) & ~rd_pending);
    end
  end

  always_comb begin
    next_readdata = 32'h00000000;
    case (AVS_ADDRESS)
      ADDR_CTRL:     next_readdata = ctrl;
      ADDR_STATUS:   next_readdata = {26'h0, xtal_on, ring_on, timer_busy,
                                      wake_vector, halted, CPU_CLK_EN};
      ADDR_IRQ_REQ:  next_readdata = {24'h0, irq_req};
      ADDR_IRQ_MASK: next_readdata = {24'h0, irq_mask};
      ADDR_CLK_SEL:  next_readdata = clk_sel;
      ADDR_ID:       next_readdata = ID_VALUE;
      default:       next_readdata = 32'h00000000;
    endcase
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      AVS_READDATA <= 32'h00000000;
    end else if (AVS_READ & ~rd_pending) begin
      AVS_READDATA <= next_readdata;
    end
  end

  // ==========================================================
  // Software registers
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      ctrl <= CTRL_RESET;
    end else if (state == HSC_HALTED) begin
      ctrl[CTRL_HALT_BIT] <= 1'h0;
      if (wr_hit && AVS_ADDRESS == ADDR_CTRL && AVS_BYTEENABLE[0]) begin
        ctrl[7:1] <= AVS_WRITEDATA[7:1];
      end
    end else if (wr_hit && AVS_ADDRESS == ADDR_CTRL && AVS_BYTEENABLE[0]) begin
      ctrl[7:0] <= AVS_WRITEDATA[7:0];
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      clk_sel <= SEL_RESET;
    end else if (wr_hit && AVS_ADDRESS == ADDR_CLK_SEL && AVS_BYTEENABLE[0]) begin
      clk_sel[7:0] <= AVS_WRITEDATA[7:0];
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      irq_mask <= MASK_RESET[7:0];
    end else if (wr_hit && AVS_ADDRESS == ADDR_IRQ_MASK && AVS_BYTEENABLE[0]) begin
      irq_mask <= AVS_WRITEDATA[7:0];
    end
  end

  // Sticky request flags; a synchronised request level beats a clear in the same cycle
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      irq_req <= 8'h00;
    end else begin
      irq_req <= (irq_req & ~((wr_hit && AVS_ADDRESS == ADDR_IRQ_REQ &&
                               AVS_BYTEENABLE[0]) ? AVS_WRITEDATA[7:0] : 8'h00))
                 | irq_sync;
    end
  end

  // ==========================================================
  // Halt state machine
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      state <= HSC_RESET_SEQ;
    end else begin
      case (state)
        HSC_RESET_SEQ: state <= HSC_RUN;
        HSC_RUN: begin
          if (HALT_REQ | ctrl[CTRL_HALT_BIT]) begin
            state <= HSC_HALTED;
          end
        end
        HSC_HALTED: begin
          if (wake) begin
            state <= HSC_WAIT;
          end
        end
        HSC_WAIT: begin
          if (timer_done) begin
            state <= HSC_RUN;
          end
        end
        default: state <= HSC_RUN;
      endcase
    end
  end

  // Wake wait length chosen from the interrupt enable at release
  assign timer_load  = halted & wake;
  assign timer_count = ctrl[CTRL_IE_BIT] ? WAIT_VECTOR_CLKS : WAIT_RESUME_CLKS;

  hsc_wake_timer u_wake_timer (
    .CLK   (CLK),
    .RESET (RESET),
    .load  (timer_load),
    .count (timer_count),
    .busy  (timer_busy),
    .done  (timer_done)
  );

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      wake_vector <= 1'h0;
    end else if (timer_load) begin
      wake_vector <= ctrl[CTRL_IE_BIT];
    end
  end

  // ==========================================================
  // CPU side outputs
  // Clock stays off through the wait so the core restarts cleanly
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      CPU_CLK_EN <= 1'h0;
    end else begin
      CPU_CLK_EN <= (state == HSC_RUN) & ~(HALT_REQ | ctrl[CTRL_HALT_BIT]);
    end
  end

  // Ports keep their values from halt entry until the core runs again
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      PORT_LATCH_HOLD <= 1'h0;
    end else if (state == HSC_RUN) begin
      PORT_LATCH_HOLD <= HALT_REQ | ctrl[CTRL_HALT_BIT];
    end else begin
      PORT_LATCH_HOLD <= (state != HSC_RESET_SEQ);
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      CPU_RESUME <= 1'h0;
      CPU_VECTOR <= 1'h0;
    end else begin
      CPU_RESUME <= timer_done & ~wake_vector;
      CPU_VECTOR <= timer_done & wake_vector;
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      CPU_RESET_VECTOR <= 1'h0;
    end else begin
      CPU_RESET_VECTOR <= (state == HSC_RESET_SEQ);
    end
  end

  // ==========================================================
  // Peripheral run enables; outside halt every unit runs
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      IT1_RUN <= 1'h0;
    end else if (!halted) begin
      IT1_RUN <= 1'h1;
    end else begin
      IT1_RUN <= xtal_on | (clk_sel[SEL_IT1_TIMER50] & clk_sel[SEL_T50_RUN]);
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      IT2_RUN <= 1'h0;
    end else if (!halted) begin
      IT2_RUN <= 1'h1;
    end else if (xtal_on && ring_on) begin
      IT2_RUN <= 1'h1;
    end else if (xtal_on) begin
      IT2_RUN <= (it2_src == IT2_SRC_CRYSTAL);
    end else if (ring_on) begin
      IT2_RUN <= (it2_src == IT2_SRC_PCLK128);
    end else begin
      IT2_RUN <= 1'h0;
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      WATCH_RUN <= 1'h0;
    end else if (!halted) begin
      WATCH_RUN <= 1'h1;
    end else begin
      WATCH_RUN <= xtal_on | clk_sel[SEL_WATCH_SUB];
    end
  end

  // Stoppable ring option trades watchdog coverage for halt current
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      WDT_RUN <= 1'h0;
    end else if (!halted) begin
      WDT_RUN <= 1'h1;
    end else begin
      WDT_RUN <= ~RING_STOPPABLE;
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      ASYNC_SERIAL_A_RUN <= 1'h0;
    end else if (!halted) begin
      ASYNC_SERIAL_A_RUN <= 1'h1;
    end else begin
      ASYNC_SERIAL_A_RUN <= xtal_on | (clk_sel[SEL_UART_T50] & clk_sel[SEL_T50_RUN]);
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      ASYNC_SERIAL_B_RUN <= 1'h0;
    end else if (!halted) begin
      ASYNC_SERIAL_B_RUN <= 1'h1;
    end else begin
      ASYNC_SERIAL_B_RUN <= xtal_on | (clk_sel[SEL_UART_T50] & clk_sel[SEL_T50_RUN]);
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      CSU_RUN <= 1'h0;
    end else if (!halted) begin
      CSU_RUN <= 1'h1;
    end else begin
      CSU_RUN <= xtal_on | clk_sel[SEL_CSU_EXT];
    end
  end

endmodule : hsc_top

/* hw/hsc_wake_timer.sv */
// Down counter that times the wake-up wait after a release
`timescale 1ns/1ps
module hsc_wake_timer (
  input  wire logic       CLK,
  input  wire logic       RESET,
  input  wire logic       load,
  input  wire logic [3:0] count,
  output logic            busy,
  output logic            done
);
  logic [3:0] remain;

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      remain <= 4'h0;
      busy   <= 1'h0;
      done   <= 1'h0;
    end else begin
      done <= 1'h0;
      if (load) begin
        remain <= count;
        busy   <= 1'h1;
      end else if (busy) begin
        if (remain == 4'h1) begin
          busy <= 1'h0;
          done <= 1'h1;
        end
        remain <= remain - 4'h1;
      end
    end
  end
endmodule : hsc_wake_timer

/* tb/hsc_cpu_model.sv */
// CPU core and interrupt source model facing the controller
`timescale 1ns/1ps
module hsc_cpu_model (
  input  wire logic       CLK,
  input  wire logic       RESET,
  input  wire logic       cpu_clk_en,
  input  wire logic       do_halt,
  input  wire logic [7:0] irq_fire,
  output logic            halt_req,
  output logic      [7:0] irq_in
);
  // ==========
  // A gated core cannot fetch, so halt issues only while clocked
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      halt_req <= 1'h0;
    end else begin
      halt_req <= do_halt && cpu_clk_en && !halt_req;
    end
  end
  // One-cycle request pulses; the controller must hold them itself
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      irq_in <= 8'h00;
    end else begin
      irq_in <= irq_fire;
    end
  end
endmodule : hsc_cpu_model

/* tb/hsc_properties.sv */
// Port assertions for the halt standby controller
`timescale 1ns/1ps
module hsc_properties #(
  parameter bit RING_STOPPABLE = 1'h0
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic HALT_REQ,
  input wire logic CPU_CLK_EN,
  input wire logic PORT_LATCH_HOLD,
  input wire logic CPU_RESUME,
  input wire logic CPU_VECTOR,
  input wire logic CPU_RESET_VECTOR,
  input wire logic WDT_RUN
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  // ==========
  // Halt entry and release
  a_halt_gates_clk:
    assert property (HALT_REQ && CPU_CLK_EN |=> !CPU_CLK_EN && PORT_LATCH_HOLD)
    else $error("halt did not gate cpu clock");
  a_wake_restores:
    assert property (CPU_RESUME || CPU_VECTOR |=> CPU_CLK_EN && !PORT_LATCH_HOLD)
    else $error("clock not back after wake");
  a_pulse_exclusive:
    assert property (!(CPU_RESUME && CPU_VECTOR))
    else $error("resume and vector together");
  a_vector_wait:
    assert property (CPU_VECTOR |-> !$past(CPU_CLK_EN, 8))
    else $error("vectored wake too short");
  a_resume_wait:
    assert property (CPU_RESUME |-> !$past(CPU_CLK_EN, 2))
    else $error("resume wake too short");
  a_reset_vector:
    assert property ($past(RESET) && !RESET |=> CPU_RESET_VECTOR ##1 CPU_CLK_EN)
    else $error("no reset vector branch");
  a_clk_cause:
    assert property ($rose(CPU_CLK_EN) |-> $past(CPU_RESUME || CPU_VECTOR || CPU_RESET_VECTOR))
    else $error("cpu clock resumed without cause");
  a_wdt_kept:
    assert property (!RING_STOPPABLE && PORT_LATCH_HOLD |-> WDT_RUN)
    else $error("watchdog stopped in halt");
endmodule : hsc_properties

bind hsc_top hsc_properties #(.RING_STOPPABLE(RING_STOPPABLE)) chk_u (
  .CLK(CLK), .RESET(RESET), .HALT_REQ(HALT_REQ), .CPU_CLK_EN(CPU_CLK_EN),
  .PORT_LATCH_HOLD(PORT_LATCH_HOLD), .CPU_RESUME(CPU_RESUME), .CPU_VECTOR(CPU_VECTOR),
  .CPU_RESET_VECTOR(CPU_RESET_VECTOR), .WDT_RUN(WDT_RUN));

/* tb/tb_top.sv */
// Self-checking bench for the halt standby controller
`timescale 1ns/1ps
module tb_top;
  import hsc_pkg::*;
  logic        CLK = 1'h0;
  logic        RESET = 1'h1;
  logic [3:0]  addr = 4'h0;
  logic        rd = 1'h0;
  logic        wr = 1'h0;
  logic [31:0] wdata = 32'h0;
  logic        do_halt = 1'h0;
  logic [7:0]  irq_fire = 8'h00;
  logic        xtal = 1'h1;
  logic        ring = 1'h1;
  logic [31:0] rdata;
  logic [7:0]  irq_in;
  logic [6:0]  en;
  logic        wdt_alt;
  logic        waitreq, halt_req, clk_en, hold, resume, vector, rst_vec;
  int          bad_count = 0;
  int          checks_done = 0;
  hsc_top #(.RING_STOPPABLE(1'h0)) dut_u (
    .CLK(CLK), .RESET(RESET), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(waitreq), .HALT_REQ(halt_req), .IRQ_IN(irq_in),
    .MAIN_CRYSTAL_RUN(xtal), .INTERNAL_RING_OSCILLATOR_RUN(ring), .CPU_CLK_EN(clk_en),
    .PORT_LATCH_HOLD(hold), .CPU_RESUME(resume), .CPU_VECTOR(vector),
    .CPU_RESET_VECTOR(rst_vec), .IT1_RUN(en[6]), .IT2_RUN(en[5]), .WATCH_RUN(en[4]),
    .WDT_RUN(en[3]), .ASYNC_SERIAL_A_RUN(en[2]), .ASYNC_SERIAL_B_RUN(en[1]),
    .CSU_RUN(en[0]));
  // Second build with a stoppable ring; only its watchdog enable is watched
  hsc_top #(.RING_STOPPABLE(1'h1)) dut_ring_u (
    .CLK(CLK), .RESET(RESET), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(),
    .AVS_WAITREQUEST(), .HALT_REQ(halt_req), .IRQ_IN(irq_in),
    .MAIN_CRYSTAL_RUN(xtal), .INTERNAL_RING_OSCILLATOR_RUN(ring), .CPU_CLK_EN(),
    .PORT_LATCH_HOLD(), .CPU_RESUME(), .CPU_VECTOR(), .CPU_RESET_VECTOR(),
    .IT1_RUN(), .IT2_RUN(), .WATCH_RUN(), .WDT_RUN(wdt_alt), .ASYNC_SERIAL_A_RUN(),
    .ASYNC_SERIAL_B_RUN(), .CSU_RUN());
  hsc_cpu_model cpu_u (.CLK(CLK), .RESET(RESET), .cpu_clk_en(clk_en), .do_halt(do_halt),
    .irq_fire(irq_fire), .halt_req(halt_req), .irq_in(irq_in));
  always #50 CLK = ~CLK;
  // ==========
  // Checks and bus cycles
  task automatic chk_word(input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: expected %h got %h", $time, exp, got);
    end
  endtask : chk_word
  task automatic chk_bit(input logic exp, input logic got);
    chk_word({31'h0, exp}, {31'h0, got});
  endtask : chk_bit
  task automatic cyc(input int n);
    repeat (n) @(posedge CLK);
  endtask : cyc
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge CLK);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    // Only the watchdog process ends a wait that never gets an answer
    do begin
      @(posedge CLK);
    end while (waitreq !== 1'h0);
    q = rdata;
    rd <= 1'h0;
    wr <= 1'h0;
  endtask : bus
  task automatic pulse(input logic [7:0] v);
    @(posedge CLK);
    irq_fire <= v;
    @(posedge CLK);
    irq_fire <= 8'h00;
  endtask : pulse
  task automatic halt();
    @(posedge CLK);
    do_halt <= 1'h1;
    @(posedge CLK);
    do_halt <= 1'h0;
    cyc(8);
  endtask : halt
  // Enables while halted; a running crystal keeps every unit but IT2 alive, and IT2 too while the ring runs
  function automatic logic [6:0] exp_en(input logic x, input logic r, input logic [6:0] s);
    logic t2;
    t2 = x ? (!r ? s[1:0] == IT2_SRC_CRYSTAL : 1'h1) : (r && s[1:0] == IT2_SRC_PCLK128);
    if (x) return {1'h1, t2, 5'h1F};
    return {s[SEL_IT1_TIMER50] & s[SEL_T50_RUN], t2, s[SEL_WATCH_SUB], 1'h1,
            {2{s[SEL_UART_T50] & s[SEL_T50_RUN]}}, s[SEL_CSU_EXT]};
  endfunction : exp_en
  // Pin to pulse: model flop, sync, sticky latch, wake edge, then the wait
  function automatic int exp_wait(input logic ie);
    return int'(ie ? WAIT_VECTOR_CLKS : WAIT_RESUME_CLKS) + 4;
  endfunction : exp_wait
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test
  // ==========
  // Main sequence
  initial begin
    logic [31:0] q;
    logic [6:0]  sel;
    logic [1:0]  sw;
    int          k;
    int          n;
    void'($urandom(32'hE572));
    cyc(8);
    RESET <= 1'h0;
    cyc(3);
    bus(1'h0, ADDR_ID, 32'h0, q);
    chk_word(ID_VALUE, q);
    bus(1'h0, ADDR_IRQ_MASK, 32'h0, q);
    chk_word(MASK_RESET, q);
    bus(1'h1, 4'hF, 32'hFFFFFFFF, q);
    bus(1'h0, 4'hF, 32'h0, q);
    chk_word(32'h0, q);
    for (int i = 0; i < 8; i++) begin
      sel = 7'($urandom);
      sw = 2'($urandom);
      k = $urandom_range(7);
      xtal <= i[0];
      ring <= i[1];
      bus(1'h1, ADDR_CLK_SEL, {25'h0, sel}, q);
      bus(1'h1, ADDR_IRQ_MASK, {24'h0, ~(8'h01 << k)}, q);
      // Software crystal stop counts; software ring stop is ignored in this build
      bus(1'h1, ADDR_CTRL, (32'(i[2]) << CTRL_IE_BIT) | (32'(sw[0]) << CTRL_RING_STOP)
          | (32'(sw[1]) << CTRL_XTAL_STOP), q);
      halt();
      chk_bit(1'h0, clk_en);
      chk_bit(1'h1, hold);
      chk_word({25'h0, exp_en(i[0] & !sw[1], i[1], sel)}, {25'h0, en});
      chk_bit(1'h0, wdt_alt);
      pulse(8'h01 << ((k + 1) % 8));
      cyc(12);
      chk_bit(1'h0, clk_en);
      pulse(8'h01 << k);
      n = 0;
      while (!(vector === 1'h1 || resume === 1'h1) && n < 40) begin
        @(posedge CLK);
        n++;
      end
      chk_bit(i[2], vector);
      chk_bit(!i[2], resume);
      chk_bit(1'h1, n >= exp_wait(i[2]) && n <= exp_wait(i[2]) + 4);
      cyc(2);
      chk_bit(1'h1, clk_en);
      chk_bit(1'h1, wdt_alt);
      bus(1'h1, ADDR_IRQ_REQ, 32'hFF, q);
    end
    // Software halt bit takes the same path as the halt instruction
    bus(1'h1, ADDR_CTRL, 32'h1 << CTRL_HALT_BIT, q);
    cyc(3);
    chk_bit(1'h0, clk_en);
    chk_bit(1'h1, hold);
    RESET <= 1'h1;
    cyc(3);
    RESET <= 1'h0;
    cyc(2);
    chk_bit(1'h1, rst_vec);
    cyc(2);
    chk_bit(1'h1, clk_en);
    chk_bit(1'h0, hold);
    finish_test();
  end
  initial begin
    // The sequence needs under 2000 cycles
    cyc(20000);
    bad_count++;
    finish_test();
  end
endmodule : tb_top
